// file: shared/err_bank_consts.vh
/*
  Constants for the error status bank: register indices (not byte
  addresses), field positions, reset values and interrupt layout.
  Assumes inclusion by bare name from design files.
*/
`ifndef ERR_BANK_CONSTS_VH
`define ERR_BANK_CONSTS_VH

// Register indices as printed; byte address is four times the index
`define IDX_SUMMARY 4'h0
`define IDX_MEMORY 4'h1
`define IDX_CFG_A 4'h2
`define IDX_PER_MOD 4'h3
`define IDX_IRQ_STAT 4'h8
`define IDX_IRQ_EN 4'h9
`define IDX_IRQ_CLR 4'hA
`define IDX_CFG_CTRL 4'hB

// Summary word bit positions
`define SUM_MEM 0
`define SUM_CFG 1
`define SUM_CHAN 2
`define SUM_LINK 4
`define SUM_IOERR 10
`define SUM_LOWERR 11
`define SUM_IOALM 12
`define SUM_LOWALM 13
`define SUM_NOTE 14

// Memory fault word bit positions
`define MEM_NVM 4
`define MEM_CAL 5
`define MEM_SET 6
`define MEM_REG 8
`define MEM_MODEL 9
`define MEM_MISMATCH 12

// First configuration fault word bit positions
`define CFG_UNKNOWN 0
`define CFG_TOO_MANY 2
`define CFG_UNIT_FAIL 3
`define CFG_NO_RESP 4

// Module count limit and field widths
`define MAX_MODULES 4'h9
`define MOD_CNT_W 4
`define UNITS 8

// Reset values
`define RST_WORD 16'h0000
`define RST_IRQ 4'h0
`define RST_CTRL 8'h00
`define RD_UNMAPPED 32'h00000000

// Interrupt status bits, one per status word changing to nonzero
`define IRQ_W 4

`endif

// file: design/err_status_bank.v
/*
  Read-only hierarchy of error status words with an Avalon-MM slave,
  a sticky interrupt status, enable and write-one-to-clear register.
  Assumes fault sources are synchronous to sys_clk and held as levels.
*/
// Register access over Avalon-MM was chosen for this implementation.
// Operation
// [R1] Summary bit 0 marks memory faults; memory word bits 4,5,6,8,9,12 detail them.
// [R2] Summary bit 1 marks a configuration fault detailed in two words.
// [R3] Summary bit 2 is set while any measurement channel is in error.
// [R4] Summary bit 4 marks expansion link failure; per-unit detail kept elsewhere.
// [R5] Summary bit 10 marks a local I/O error.
// [R6] Summary bit 11 marks an error reported by an expansion unit.
// [R7] Summary bit 12 marks an active local I/O alarm.
// [R8] Summary bit 13 marks an alarm in any expansion unit.
// [R9] Summary bit 14 marks a pending I/O notification.
// [R10] Config word A bit 0 flags an unrecognised module type.
// [R11] Config word A bit 2 flags more than nine attached modules.
// [R12] Config word A bit 3 flags failed module communication.
// [R13] Config word A bit 4 flags a registered module that stopped answering.
// [R14] Per-module word bit n-1 flags failed communication with module n.
// [R15] Unused bits read zero; writes to status words are ignored.
// [R16] Summary bits 0 and 1 are ORs of detail words, updated in the same cycle.
`timescale 1ns/1ps
`include "err_bank_consts.vh"
`default_nettype none

module err_status_bank #(
  parameter UNITS = `UNITS
) (
  input wire sys_clk,
  input wire rstn,
  input wire [5:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  output reg irq,
  output reg [15:0] summary_out,
  input wire fault_nvm,
  input wire fault_cal,
  input wire fault_setting,
  input wire fault_registration,
  input wire fault_model,
  input wire fault_model_mismatch,
  input wire module_unknown,
  input wire [`MOD_CNT_W-1:0] module_count,
  input wire [UNITS-1:0] module_comm_fail,
  input wire [UNITS-1:0] module_registered,
  input wire [UNITS-1:0] module_responding,
  input wire any_channel_error,
  input wire link_fault,
  input wire io_error,
  input wire lower_io_error,
  input wire io_alarm,
  input wire lower_io_alarm,
  input wire io_notification
);

  reg [15:0] summary_r;
  reg [15:0] memory_r;
  reg [15:0] cfg_a_r;
  reg [15:0] per_mod_r;
  reg [`IRQ_W-1:0] irq_stat_r;
  reg [`IRQ_W-1:0] irq_en_r;
  reg [7:0] cfg_ctrl_r;
  reg [`IRQ_W-1:0] prev_nz_r;
  reg [31:0] readdata_nxt;
  reg [15:0] memory_nxt;
  reg [15:0] cfg_a_nxt;
  reg [15:0] per_mod_nxt;
  reg [15:0] summary_nxt;
  reg [`IRQ_W-1:0] irq_stat_nxt;
  reg [`IRQ_W-1:0] irq_en_nxt;
  reg [7:0] cfg_ctrl_nxt;
  wire [`IRQ_W-1:0] nz_now;
  wire [`IRQ_W-1:0] rise;
  wire [3:0] idx;
  wire access;
  wire wr_hit;

  function nonzero;
    input [15:0] w;
    begin
      nonzero = |w;
    end
  endfunction

  assign idx = avs_address[5:2];
  assign access = (avs_read | avs_write) & avs_waitrequest;
  // Write lands on the edge that the master sees waitrequest low
  assign wr_hit = avs_write & ~avs_waitrequest & avs_byteenable[0];

  // Detail words, built from live fault levels
  always @*
  begin
    memory_nxt = `RST_WORD;
    memory_nxt[`MEM_NVM] = fault_nvm; // [R1]
    memory_nxt[`MEM_CAL] = fault_cal; // [R1]
    memory_nxt[`MEM_SET] = fault_setting; // [R1]
    memory_nxt[`MEM_REG] = fault_registration; // [R1]
    memory_nxt[`MEM_MODEL] = fault_model; // [R1]
    memory_nxt[`MEM_MISMATCH] = fault_model_mismatch; // [R1]
    cfg_a_nxt = `RST_WORD;
    cfg_a_nxt[`CFG_UNKNOWN] = module_unknown; // [R10]
    cfg_a_nxt[`CFG_TOO_MANY] = module_count > `MAX_MODULES; // [R11]
    cfg_a_nxt[`CFG_UNIT_FAIL] = |module_comm_fail; // [R12]
    // Only a registered module can count as having stopped answering
    cfg_a_nxt[`CFG_NO_RESP] =
      |(module_registered & ~module_responding); // [R13]
    per_mod_nxt = `RST_WORD;
    per_mod_nxt[UNITS-1:0] = module_comm_fail; // [R14]
  end

  // Summary from the next detail values so both land on one edge
  always @*
  begin
    summary_nxt = `RST_WORD;
    summary_nxt[`SUM_MEM] = nonzero(memory_nxt); // [R1] [R16]
    summary_nxt[`SUM_CFG] =
      nonzero(cfg_a_nxt) | nonzero(per_mod_nxt); // [R2] [R16]
    summary_nxt[`SUM_CHAN] = any_channel_error; // [R3]
    summary_nxt[`SUM_LINK] = link_fault; // [R4]
    summary_nxt[`SUM_IOERR] = io_error; // [R5]
    summary_nxt[`SUM_LOWERR] = lower_io_error; // [R6]
    summary_nxt[`SUM_IOALM] = io_alarm; // [R7]
    summary_nxt[`SUM_LOWALM] = lower_io_alarm; // [R8]
    summary_nxt[`SUM_NOTE] = io_notification; // [R9]
  end

  assign nz_now = {nonzero(per_mod_r), nonzero(cfg_a_r),
                   nonzero(memory_r), nonzero(summary_r)};
  assign rise = nz_now & ~prev_nz_r;

  // Sticky status: a new event beats a clear in the same cycle
  always @*
  begin
    irq_stat_nxt = irq_stat_r;
    irq_en_nxt = irq_en_r;
    cfg_ctrl_nxt = cfg_ctrl_r;
    if (wr_hit && idx == `IDX_IRQ_CLR)
      irq_stat_nxt = irq_stat_nxt & ~avs_writedata[`IRQ_W-1:0];
    if (wr_hit && idx == `IDX_IRQ_EN)
      irq_en_nxt = avs_writedata[`IRQ_W-1:0];
    if (wr_hit && idx == `IDX_CFG_CTRL)
      cfg_ctrl_nxt = avs_writedata[7:0];
    irq_stat_nxt = irq_stat_nxt | rise;
  end

  // Status words have no write path at all
  always @*
  begin
    case (idx)
      `IDX_SUMMARY: readdata_nxt = {16'h0000, summary_r}; // [R15]
      `IDX_MEMORY: readdata_nxt = {16'h0000, memory_r}; // [R15]
      `IDX_CFG_A: readdata_nxt = {16'h0000, cfg_a_r}; // [R15]
      `IDX_PER_MOD: readdata_nxt = {16'h0000, per_mod_r}; // [R15]
      `IDX_IRQ_STAT: readdata_nxt = {28'h0000000, irq_stat_r};
      `IDX_IRQ_EN: readdata_nxt = {28'h0000000, irq_en_r};
      `IDX_CFG_CTRL: readdata_nxt = {24'h000000, cfg_ctrl_r};
      default: readdata_nxt = `RD_UNMAPPED;
    endcase
  end

  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      summary_r <= `RST_WORD;
      memory_r <= `RST_WORD;
      cfg_a_r <= `RST_WORD;
      per_mod_r <= `RST_WORD;
      irq_stat_r <= `RST_IRQ;
      irq_en_r <= `RST_IRQ;
      cfg_ctrl_r <= `RST_CTRL;
      prev_nz_r <= `RST_IRQ;
      avs_readdata <= `RD_UNMAPPED;
      avs_waitrequest <= 1'b1;
      irq <= 1'b0;
      summary_out <= `RST_WORD;
    end
    else
    begin
      memory_r <= memory_nxt;
      cfg_a_r <= cfg_a_nxt;
      per_mod_r <= per_mod_nxt;
      summary_r <= summary_nxt; // [R16]
      summary_out <= summary_nxt;
      prev_nz_r <= nz_now;
      irq_stat_r <= irq_stat_nxt;
      irq_en_r <= irq_en_nxt;
      cfg_ctrl_r <= cfg_ctrl_nxt;
      irq <= |(irq_stat_nxt & irq_en_nxt);
      // One wait cycle per access, then waitrequest drops for one edge
      if (access)
        avs_waitrequest <= 1'b0;
      else
        avs_waitrequest <= 1'b1;
      if (avs_read && avs_waitrequest)
        avs_readdata <= readdata_nxt;
    end
  end

endmodule // err_status_bank

`default_nettype wire

// file: sim/err_status_bank_assertions.sv
/* Checker for the error status bank: bus answer timing, summary bits.
   Assumes binding onto err_status_bank and its port names. */
`timescale 1ns/1ps
`default_nettype none
module err_status_bank_assertions #(
  parameter UNITS = 8
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic [31:0] avs_readdata,
  input wire logic [15:0] summary_out,
  input wire logic fault_nvm,
  input wire logic [3:0] module_count,
  input wire logic [UNITS-1:0] module_comm_fail,
  input wire logic any_channel_error
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  wire req = avs_read | avs_write;
  chk_wait_answer: assert property
    (req && avs_waitrequest |=> !avs_waitrequest) else $error("late ack");
  chk_wait_pulse: assert property
    (!avs_waitrequest |=> avs_waitrequest) else $error("long ack");
  chk_wait_idle: assert property
    (!req |=> avs_waitrequest) else $error("ack unasked");
  chk_read_upper: assert property
    (!avs_waitrequest |-> avs_readdata[31:16] == 16'h0000)
    else $error("upper bits");
  chk_sum_unused: assert property
    ((summary_out & 16'h83E8) == 16'h0000) else $error("unused bit");
  chk_chan_follow: assert property
    (1'b1 |=> summary_out[2] == $past(any_channel_error))
    else $error("chan bit");
  chk_mem_sum: assert property
    (fault_nvm |=> summary_out[0]) else $error("mem bit");
  chk_count_sum: assert property
    (module_count > 4'h9 |=> summary_out[1]) else $error("count bit");
  chk_unit_sum: assert property
    (|module_comm_fail |=> summary_out[1]) else $error("unit bit");
  cover property (req && !avs_waitrequest);
  cover property (module_count > 4'h9);
  cover property (summary_out[14]);
endmodule // err_status_bank_assertions
bind err_status_bank err_status_bank_assertions #(.UNITS(UNITS)) chk_u (.*);
`default_nettype wire

// file: sim/avm_host.sv
/* Avalon-MM host model: one read or write per call.
   Assumes the slave answers by dropping waitrequest. */
`timescale 1ns/1ps
`default_nettype none
module avm_host (
  input wire logic sys_clk,
  output logic [5:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  input wire logic avs_waitrequest
);
  initial {avs_address, avs_read, avs_write, avs_writedata} = '0;
  // Leading edge keeps two calls from driving in one time step
  task automatic xfer(input logic w, input logic [3:0] i,
    input logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= {i, 2'h0};
    avs_read <= !w;
    avs_write <= w;
    avs_writedata <= d;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
endmodule // avm_host
`default_nettype wire

// file: sim/err_status_bank_tb.sv
/* Bench for err_status_bank: fault levels in, status words read back.
   Assumes avm_host and the checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module err_status_bank_tb;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic [13:0] f = '0;
  logic [3:0] cnt = '0;
  logic [7:0] cf = '0, rg = '0, rp = '0;
  logic [5:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest, irq;
  logic [31:0] avs_writedata, avs_readdata;
  logic [15:0] summary_out;
  int err_total = 0, n_compared = 0;
  always #5 sys_clk = ~sys_clk;
  avm_host host_u (.*);
  err_status_bank dut_u (.*, .avs_byteenable(4'hF), .fault_nvm(f[0]),
    .fault_cal(f[1]), .fault_setting(f[2]), .fault_registration(f[3]),
    .fault_model(f[4]), .fault_model_mismatch(f[5]),
    .module_unknown(f[6]), .module_count(cnt), .module_comm_fail(cf),
    .module_registered(rg), .module_responding(rp),
    .any_channel_error(f[7]), .link_fault(f[8]), .io_error(f[9]),
    .lower_io_error(f[10]), .io_alarm(f[11]), .lower_io_alarm(f[12]),
    .io_notification(f[13]));
  task automatic chk(input string nm, input logic [31:0] s, e);
    n_compared++;
    if (s !== e)
    begin
      err_total++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask
  function automatic logic [15:0] model(input int i);
    logic [15:0] m, a;
    m = {3'h0, f[5], 2'h0, f[4:3], 1'h0, f[2:0], 4'h0};
    a = {11'h0, |(rg & ~rp), |cf, cnt > 4'h9, 1'h0, f[6]};
    case (i)
      0: return {1'h0, f[13:9], 5'h0, f[8], 1'h0, f[7], |{a, cf}, |m};
      1: return m;
      2: return a;
      default: return {8'h00, cf};
    endcase
  endfunction
  task automatic rd(input string nm, input logic [3:0] i,
    input logic [31:0] e);
    host_u.xfer(1'b0, i, 32'h0);
    chk(nm, avs_readdata, e);
  endtask
  task automatic settle_check();
    repeat (4) @(posedge sys_clk);
    chk("summary_out", {16'h0, summary_out}, {16'h0, model(0)});
    for (int i = 0; i < 4; i++)
      rd("status word", i[3:0], {16'h0, model(i)});
  endtask
  task automatic tally_and_finish();
    if (err_total == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    settle_check();
    rd("unmapped", 4'hC, 32'h0);
    host_u.xfer(1'b1, 4'hB, 32'hA5);
    rd("scratch", 4'hB, 32'hA5);
    host_u.xfer(1'b1, 4'hC, 32'hFF);
    rd("unmapped wr", 4'hC, 32'h0);
    for (int b = 0; b < 14; b++)
    begin
      f <= 14'h0001 << b;
      settle_check();
    end
    f <= '0;
    for (int c = 9; c < 11; c++)
    begin
      cnt <= c[3:0];
      settle_check();
    end
    cnt <= '0;
    for (int n = 0; n < 8; n++)
    begin
      cf <= 8'h01 << n;
      settle_check();
    end
    {cf, rg, rp} <= {8'h00, 8'h81, 8'h01};
    settle_check();
    {rp, f} <= {8'h81, 14'h0001};
    for (int i = 0; i < 4; i++)
      host_u.xfer(1'b1, i[3:0], 32'hFFFF);
    settle_check();
    f <= '0;
    host_u.xfer(1'b1, 4'hA, 32'hF);
    host_u.xfer(1'b1, 4'h9, 32'h2);
    rd("irq enable", 4'h9, 32'h2);
    f <= 14'h0001;
    settle_check();
    chk("irq", irq, 32'h1);
    f <= '0;
    host_u.xfer(1'b1, 4'hA, 32'h3);
    repeat (2) @(posedge sys_clk);
    chk("irq", irq, 32'h0);
    rd("irq status", 4'h8, 32'h0);
    host_u.xfer(1'b1, 4'h9, 32'h0);
    f <= 14'h0001;
    settle_check();
    chk("irq masked", irq, 32'h0);
    rd("irq status", 4'h8, 32'h3);
    tally_and_finish();
  end
  initial
  begin
    #100000;
    err_total++;
    tally_and_finish();
  end
endmodule // err_status_bank_tb
`default_nettype wire
